/* File: ulf_pkg.sv */
// constants and helpers shared by the line format control block
`default_nettype none
package ulf_pkg;
    // register byte offsets
    localparam logic [7:0] ULF_OFS_LFC  = 8'h00;
    localparam logic [7:0] ULF_OFS_TXD  = 8'h04;
    localparam logic [7:0] ULF_OFS_RXD  = 8'h08;
    localparam logic [7:0] ULF_OFS_DIV  = 8'h0C;
    localparam logic [7:0] ULF_OFS_EFR  = 8'h10;
    localparam logic [7:0] ULF_OFS_IST  = 8'h14;
    localparam logic [7:0] ULF_OFS_IMSK = 8'h18;
    // line_format_control fields
    localparam int ULF_B_DLAB  = 7;
    localparam int ULF_B_BRK   = 6;
    localparam int ULF_B_STICK = 5;
    localparam int ULF_B_EVEN  = 4;
    localparam int ULF_B_PEN   = 3;
    localparam int ULF_B_STOP  = 2;
    localparam int ULF_B_WL_HI = 1;
    localparam int ULF_B_WL_LO = 0;
    // receive data register status fields
    localparam int ULF_B_RX_PERR = 8;
    localparam int ULF_B_RX_FERR = 9;
    localparam int ULF_B_TX_BUSY = 10;
    // event bits of status and mask registers
    localparam int ULF_EV_TXDONE = 0;
    localparam int ULF_EV_RXDONE = 1;
    localparam int ULF_EV_PERR   = 2;
    localparam int ULF_EV_FERR   = 3;
    localparam int ULF_EV_N      = 4;
    // reset values
    localparam logic [7:0]  ULF_RST_LFC = 8'h00;
    localparam logic [15:0] ULF_RST_DIV = 16'h0001;
    localparam logic [7:0]  ULF_RST_EFR = 8'h00;
    // bit timing in 16x oversample ticks
    localparam logic [5:0] ULF_TK_BIT  = 6'h10;
    localparam logic [5:0] ULF_TK_HALF = 6'h07;
    localparam logic [5:0] ULF_TK_S15  = 6'h18;
    localparam logic [5:0] ULF_TK_S2   = 6'h20;

    // parity bit over the configured data bits only
    function automatic logic ulf_par_bit(input logic [7:0] d, input logic [1:0] wl,
                                         input logic even, input logic stick);
        logic [7:0] m;
        m = 8'hFF >> (2'h3 - wl);
        if (stick)
            return ~even;
        return even ? ^(d & m) : ~^(d & m);
    endfunction : ulf_par_bit

    function automatic logic [5:0] ulf_stop_ticks(input logic stop, input logic [1:0] wl);
        if (!stop)
            return ULF_TK_BIT;
        return (wl == 2'h0) ? ULF_TK_S15 : ULF_TK_S2;
    endfunction : ulf_stop_ticks
endpackage : ulf_pkg
`default_nettype wire

/* File: ulf_fmt_if.sv */
// character format and baud tick carried from the register file to tx and rx
`default_nettype none
interface ulf_fmt_if;
    logic [1:0] wlen;
    logic       stop2;
    logic       par_en;
    logic       par_even;
    logic       par_stick;
    logic       tick16;
    modport src (output wlen, stop2, par_en, par_even, par_stick, tick16);
    modport snk (input wlen, stop2, par_en, par_even, par_stick, tick16);
endinterface : ulf_fmt_if
`default_nettype wire

/* File: ulf_tx.sv */
// serial transmitter following the configured character format
`default_nettype none
module ulf_tx
    import ulf_pkg::*;
(
    input  wire logic       clk,      // system clock
    input  wire logic       rst,      // sync reset
    ulf_fmt_if.snk          fmt,      // format and tick
    input  wire logic       start,    // one-cycle send request
    input  wire logic [7:0] data,     // character to send
    output logic            line,     // serial line before break
    output logic            busy,     // frame in progress
    output logic            done      // one-cycle frame end
);
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b011,
        TX_PAR   = 3'b010,
        TX_STOP  = 3'b110
    } ulf_txst_e;

    ulf_txst_e  state_reg;
    logic [5:0] tick_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] data_reg;
    logic       par_reg;
    logic [5:0] lim;
    logic       tick_end;

    assign lim      = (state_reg == TX_STOP) ? ulf_stop_ticks(fmt.stop2, fmt.wlen) : ULF_TK_BIT;
    assign tick_end = fmt.tick16 && (tick_reg == lim - 6'h01);

    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            state_reg <= TX_IDLE;
            tick_reg  <= 6'h00;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            data_reg  <= 8'h00;
            par_reg   <= 1'b0;
            line      <= 1'b1;
            busy      <= 1'b0;
        end else begin
            if (fmt.tick16)
                tick_reg <= tick_end ? 6'h00 : tick_reg + 6'h01;
            unique case (state_reg)
                TX_IDLE: begin
                    tick_reg <= 6'h00;
                    if (start) begin
                        shift_reg <= data;
                        data_reg  <= data;
                        par_reg   <= ulf_par_bit(data, fmt.wlen, fmt.par_even, fmt.par_stick);
                        line      <= 1'b0;
                        busy      <= 1'b1;
                        state_reg <= TX_START;
                    end
                end
                TX_START: if (tick_end) begin
                    line      <= shift_reg[0];
                    bit_reg   <= 3'h0;
                    state_reg <= TX_DATA;
                end
                TX_DATA: if (tick_end) begin
                    if (bit_reg == 3'h4 + {1'b0, fmt.wlen}) begin
                        if (fmt.par_en) begin
                            line      <= par_reg;
                            state_reg <= TX_PAR;
                        end else begin
                            line      <= 1'b1;
                            state_reg <= TX_STOP;
                        end
                    end else begin
                        bit_reg   <= bit_reg + 3'h1;
                        shift_reg <= shift_reg >> 1;
                        line      <= shift_reg[1];
                    end
                end
                TX_PAR: if (tick_end) begin
                    line      <= 1'b1;
                    state_reg <= TX_STOP;
                end
                TX_STOP: if (tick_end) begin
                    busy      <= 1'b0;
                    done      <= 1'b1;
                    state_reg <= TX_IDLE;
                end
                default: state_reg <= TX_IDLE;
            endcase
        end
    end

    // helper: ticks spent in the stop state
    logic [5:0] stop_seen;
    always_ff @(posedge clk) begin
        if (rst || state_reg != TX_STOP)
            stop_seen <= 6'h00;
        else if (fmt.tick16)
            stop_seen <= stop_seen + 6'h01;
    end

    par_value_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == TX_PAR) |-> fmt.par_en && line == (fmt.par_stick ? ~fmt.par_even
            : (^(data_reg & (8'hFF >> (2'h3 - fmt.wlen))) ^ ~fmt.par_even)))
        else $error("parity bit value wrong");
    word_len_a: assert property (@(posedge clk) disable iff (rst)
        ($past(state_reg) == TX_DATA && state_reg != TX_DATA) |-> $past(bit_reg) == {1'b1, fmt.wlen})
        else $error("wrong number of data bits");
    par_order_a: assert property (@(posedge clk) disable iff (rst)
        ($past(state_reg) == TX_DATA && state_reg != TX_DATA)
        |-> state_reg == (fmt.par_en ? TX_PAR : TX_STOP))
        else $error("parity slot misplaced");
    stop_len_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == TX_STOP && tick_end) |-> stop_seen + 6'h01 ==
            (fmt.stop2 ? ((fmt.wlen == 2'h0) ? 6'h18 : 6'h20) : 6'h10))
        else $error("stop length wrong");
endmodule : ulf_tx
`default_nettype wire

/* File: ulf_rx.sv */
// serial receiver with parity and stop checking
`default_nettype none
module ulf_rx
    import ulf_pkg::*;
(
    input  wire logic       clk,      // system clock
    input  wire logic       rst,      // sync reset
    ulf_fmt_if.snk          fmt,      // format and tick
    input  wire logic       rxd,      // serial input
    output logic [7:0]      data,     // received character
    output logic            par_err,  // parity mismatch of last character
    output logic            frm_err,  // stop bit low on last character
    output logic            done      // one-cycle character end
);
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b011,
        RX_PAR   = 3'b010,
        RX_STOP  = 3'b110
    } ulf_rxst_e;

    ulf_rxst_e  state_reg;
    logic [5:0] tick_reg;
    logic [2:0] bit_reg;
    logic       perr_reg;
    logic       mid;

    // sampling when the counter reads 15, 16 ticks after the start-bit centre, lands mid bit
    assign mid = fmt.tick16 && (tick_reg == ULF_TK_BIT - 6'h01);

    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            state_reg <= RX_IDLE;
            tick_reg  <= 6'h00;
            bit_reg   <= 3'h0;
            perr_reg  <= 1'b0;
            data      <= 8'h00;
            par_err   <= 1'b0;
            frm_err   <= 1'b0;
        end else begin
            if (fmt.tick16)
                tick_reg <= mid ? 6'h00 : tick_reg + 6'h01;
            unique case (state_reg)
                RX_IDLE: begin
                    tick_reg <= 6'h00;
                    if (fmt.tick16 && !rxd)
                        state_reg <= RX_START;
                end
                RX_START: if (fmt.tick16 && tick_reg == ULF_TK_HALF) begin
                    // a glitch shorter than half a bit is dropped
                    tick_reg  <= 6'h00;
                    bit_reg   <= 3'h0;
                    perr_reg  <= 1'b0;
                    data      <= 8'h00;
                    state_reg <= rxd ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (mid) begin
                    data[bit_reg] <= rxd;
                    bit_reg       <= bit_reg + 3'h1;
                    if (bit_reg == 3'h4 + {1'b0, fmt.wlen})
                        state_reg <= fmt.par_en ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (mid) begin
                    perr_reg  <= rxd != ulf_par_bit(data, fmt.wlen, fmt.par_even,
                                                    fmt.par_stick);
                    state_reg <= RX_STOP;
                end
                RX_STOP: if (mid) begin
                    par_err   <= perr_reg;
                    frm_err   <= !rxd;
                    done      <= 1'b1;
                    state_reg <= RX_IDLE;
                end
                default: state_reg <= RX_IDLE;
            endcase
        end
    end

    par_check_a: assert property (@(posedge clk) disable iff (rst)
        ($past(state_reg) == RX_DATA && state_reg == RX_STOP) |-> !fmt.par_en ##1 !perr_reg)
        else $error("parity checked while disabled");
endmodule : ulf_rx
`default_nettype wire

/* File: ulf_top.sv */
// line format control for one serial channel, with apb registers
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - bit 7 opens divisor and enhanced registers
// - bit 6 holds transmit line low
// - bit 3 adds a parity bit
// - receiver checks parity when enabled
// - bit 4 picks even or odd parity
// - bit 5 forces parity to inverse of bit 4
// - bit 2 gives one, 1.5 or two stops
// - bits 1:0 give five to eight data bits
// - all format bits reset to zero
module ulf_top
    import ulf_pkg::*;
(
    input  wire logic        clk,      // 50 MHz system clock
    input  wire logic        rst,      // sync reset, active high
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb access phase
    input  wire logic        pwrite,   // apb write
    input  wire logic [7:0]  paddr,    // apb byte address
    input  wire logic [31:0] pwdata,   // apb write data
    output logic      [31:0] prdata,   // apb read data
    output logic             pready,   // apb ready
    output logic             pslverr,  // apb error
    input  wire logic        rxd,      // serial input
    output logic             txd,      // serial output
    output logic             irq       // level interrupt
);
    ////////////////////////////////////////////////////////////////////////////
    // registers and wiring
    logic [7:0]          lfc_reg;
    logic [15:0]         div_reg;
    logic [7:0]          efr_reg;
    logic [ULF_EV_N-1:0] ist_reg;
    logic [ULF_EV_N-1:0] imsk_reg;
    logic [15:0]         div_cnt_reg;
    logic                tick_reg;
    logic                tx_start_reg;
    logic [7:0]          tx_data_reg;
    logic                tx_line;
    logic                tx_busy;
    logic                tx_done;
    logic [7:0]          rx_data;
    logic                rx_perr;
    logic                rx_ferr;
    logic                rx_done;
    logic [16:0]         cnt_inc;
    logic                dlab;
    logic                setup;
    logic                acc;
    logic                wr;
    logic                hidden;
    logic                mapped;
    logic [31:0]         rd_next;
    logic [ULF_EV_N-1:0] ev;

    ulf_fmt_if fmt ();

    assign dlab = lfc_reg[ULF_B_DLAB];
    assign fmt.wlen      = lfc_reg[ULF_B_WL_HI:ULF_B_WL_LO];
    assign fmt.stop2     = lfc_reg[ULF_B_STOP];
    assign fmt.par_en    = lfc_reg[ULF_B_PEN];
    // with parity off the sub-blocks never look at even and stick
    assign fmt.par_even  = lfc_reg[ULF_B_EVEN];
    assign fmt.par_stick = lfc_reg[ULF_B_STICK];
    assign fmt.tick16    = tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: answer in the first access cycle
    assign setup  = psel && !penable;
    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite;
    // divisor and enhanced registers vanish from the map while bit 7 is low
    assign hidden = (paddr == ULF_OFS_DIV || paddr == ULF_OFS_EFR) && !dlab;
    assign mapped = !hidden && (paddr == ULF_OFS_LFC || paddr == ULF_OFS_TXD ||
                    paddr == ULF_OFS_RXD || paddr == ULF_OFS_DIV ||
                    paddr == ULF_OFS_EFR || paddr == ULF_OFS_IST ||
                    paddr == ULF_OFS_IMSK);

    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (paddr)
            ULF_OFS_LFC:  rd_next[7:0] = lfc_reg;
            ULF_OFS_RXD: begin
                rd_next[7:0]          = rx_data;
                rd_next[ULF_B_RX_PERR] = rx_perr;
                rd_next[ULF_B_RX_FERR] = rx_ferr;
                rd_next[ULF_B_TX_BUSY] = tx_busy;
            end
            ULF_OFS_DIV:  if (dlab) rd_next[15:0] = div_reg;
            ULF_OFS_EFR:  if (dlab) rd_next[7:0] = efr_reg;
            ULF_OFS_IST:  rd_next[ULF_EV_N-1:0] = ist_reg;
            ULF_OFS_IMSK: rd_next[ULF_EV_N-1:0] = imsk_reg;
            default:      rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup)
                prdata <= (mapped && !pwrite) ? rd_next : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // format register
    always_ff @(posedge clk) begin
        if (rst)
            lfc_reg <= ULF_RST_LFC;
        else if (wr && paddr == ULF_OFS_LFC)
            lfc_reg <= pwdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= ULF_RST_DIV;
            efr_reg <= ULF_RST_EFR;
        end else if (wr && dlab) begin
            if (paddr == ULF_OFS_DIV)
                div_reg <= pwdata[15:0];
            if (paddr == ULF_OFS_EFR)
                efr_reg <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 16x baud tick; divisor 0 behaves as 1
    assign cnt_inc = {1'b0, div_cnt_reg} + 17'h0_0001;

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_reg <= 16'h0000;
            tick_reg    <= 1'b0;
        end else if (cnt_inc >= {1'b0, div_reg}) begin
            div_cnt_reg <= 16'h0000;
            tick_reg    <= 1'b1;
        end else begin
            div_cnt_reg <= cnt_inc[15:0];
            tick_reg    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit request: a write while busy is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_start_reg <= 1'b0;
            tx_data_reg  <= 8'h00;
        end else begin
            tx_start_reg <= wr && paddr == ULF_OFS_TXD && !tx_busy && !tx_start_reg;
            if (wr && paddr == ULF_OFS_TXD && !tx_busy && !tx_start_reg)
                tx_data_reg <= pwdata[7:0];
        end
    end

    ulf_tx u_tx (
        .clk   (clk),
        .rst   (rst),
        .fmt   (fmt.snk),
        .start (tx_start_reg),
        .data  (tx_data_reg),
        .line  (tx_line),
        .busy  (tx_busy),
        .done  (tx_done)
    );

    ulf_rx u_rx (
        .clk     (clk),
        .rst     (rst),
        .fmt     (fmt.snk),
        .rxd     (rxd),
        .data    (rx_data),
        .par_err (rx_perr),
        .frm_err (rx_ferr),
        .done    (rx_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // line output; break overrides whatever the transmitter is doing
    always_ff @(posedge clk) begin
        if (rst)
            txd <= 1'b1;
        else
            txd <= lfc_reg[ULF_B_BRK] ? 1'b0 : tx_line;
    end

    ////////////////////////////////////////////////////////////////////////////
    // events, write one to clear; a new event beats a clear in the same cycle
    always_comb begin
        ev                = '0;
        ev[ULF_EV_TXDONE] = tx_done;
        ev[ULF_EV_RXDONE] = rx_done;
        ev[ULF_EV_PERR]   = rx_done && rx_perr;
        ev[ULF_EV_FERR]   = rx_done && rx_ferr;
    end

    always_ff @(posedge clk) begin
        if (rst)
            ist_reg <= '0;
        else if (wr && paddr == ULF_OFS_IST)
            ist_reg <= (ist_reg & ~pwdata[ULF_EV_N-1:0]) | ev;
        else
            ist_reg <= ist_reg | ev;
    end

    always_ff @(posedge clk) begin
        if (rst)
            imsk_reg <= '0;
        else if (wr && paddr == ULF_OFS_IMSK)
            imsk_reg <= pwdata[ULF_EV_N-1:0];
    end

    always_ff @(posedge clk) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(ist_reg & imsk_reg);
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    brk_hold_a: assert property (@(posedge clk) disable iff (rst)
        lfc_reg[ULF_B_BRK] |=> !txd)
        else $error("break did not hold line low");
    dlab_hide_a: assert property (@(posedge clk) disable iff (rst)
        (setup && !dlab && paddr == ULF_OFS_DIV) |=> pslverr && prdata == 32'h0)
        else $error("divisor visible while hidden");
    fmt_reset_a: assert property (@(posedge clk)
        $past(rst) |-> lfc_reg == 8'h00 && !fmt.par_en && fmt.wlen == 2'h0)
        else $error("format not zero after reset");
    stick_par_a: assert property (@(posedge clk) disable iff (rst)
        (fmt.par_en && fmt.par_stick && u_tx.state_reg == 3'b010)
        |-> tx_line == !fmt.par_even)
        else $error("forced parity value wrong");

    // a hidden register must not change, not even on a read
    hidden_lock_a: assert property (
        @(posedge clk) disable iff (rst)
        (acc && !dlab && (paddr == ULF_OFS_DIV || paddr == ULF_OFS_EFR))
        |=> $stable(div_reg) && $stable(efr_reg))
        else $error("hidden register changed");

    dlab_open_a: assert property (
        @(posedge clk) disable iff (rst)
        (setup && dlab && !pwrite && paddr == ULF_OFS_EFR)
        |=> !pslverr && prdata == {24'h00_0000, $past(efr_reg)})
        else $error("enhanced read wrong");

    brk_release_a: assert property (
        @(posedge clk) disable iff (rst)
        !lfc_reg[ULF_B_BRK]
        |=> txd == $past(tx_line))
        else $error("line not from transmitter");

    wlen_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr && paddr == ULF_OFS_LFC)
        |=> fmt.wlen == $past(pwdata[1:0]))
        else $error("word length not taken");

    perr_event_a: assert property (
        @(posedge clk) disable iff (rst)
        (rx_done && rx_perr)
        |=> ist_reg[ULF_EV_PERR])
        else $error("parity event lost");

    ev_wins_a: assert property (
        @(posedge clk) disable iff (rst)
        (|ev)
        |=> (ist_reg & $past(ev)) == $past(ev))
        else $error("event lost to clear");

    // irq trails the status and mask by one flop
    irq_level_a: assert property (
        @(posedge clk) disable iff (rst)
        1'b1
        |=> irq == $past(|(ist_reg & imsk_reg)))
        else $error("irq level wrong");

    // a master that holds penable must not see a second ready
    pready_pulse_a: assert property (
        @(posedge clk) disable iff (rst)
        pready
        |=> !pready)
        else $error("ready longer than one cycle");

    err_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        (setup && !mapped)
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
endmodule : ulf_top
`default_nettype wire

/* File: ulf_remote.sv */
// remote serial end: sends frames on rxd and samples frames seen on txd
`default_nettype none
module ulf_remote (
    input  wire logic clk,  // system clock
    input  wire logic txd,  // line from the block
    output var logic  rxd   // line to the block, idle high
);
    timeunit 1ns;
    timeprecision 1ps;
    int          cyc = 0;  // free-running cycle count
    int          t0;       // cycle at which the last start bit was seen
    logic [11:0] smp;      // mid-bit samples after the start bit
    initial rxd = 1'b1;
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////////
    // divisor stays at one, so a bit lasts 16 clocks
    task automatic send(input logic [7:0] d, input int n, input logic pen, input logic p);
        rxd <= 1'b0;
        repeat (16) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= d[i];
            repeat (16) @(posedge clk);
        end
        if (pen) begin
            rxd <= p;
            repeat (16) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (16) @(posedge clk);
    endtask : send
    // stops sampling in mid stop bit so the caller can still time the frame end
    task automatic grab(input int nb);
        smp = 12'hFFF;
        while (txd !== 1'b0) @(posedge clk);
        t0 = cyc;
        repeat (8) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            repeat (16) @(posedge clk);
            smp[i] = txd;
        end
    endtask : grab
endmodule : ulf_remote
`default_nettype wire

/* File: uart_line_format_control_test.sv */
// self-checking bench for the line format control block
`default_nettype none
module uart_line_format_control_test
    import ulf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, rxd, txd, irq, er;
    int          n_errors = 0, check_count = 0, cycles = 0;
    ulf_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    ulf_remote u_rem (.clk(clk), .txd(txd), .rxd(rxd));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wirq();
        while (irq !== 1'b1) @(posedge clk);
    endtask : wirq
    // parity over the configured data bits only
    function automatic logic par(input logic [7:0] f, input logic [7:0] d);
        logic [7:0] dm;
        dm = d & 8'((1 << (5 + f[1:0])) - 1);
        return f[5] ? ~f[4] : (^dm) ^ ~f[4];
    endfunction : par
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_tx(input logic [7:0] f, input logic [7:0] d);
        int n, np, st, len, t;
        logic [11:0] e;
        n = 5 + f[1:0];
        np = f[3];
        st = !f[2] ? 16 : (f[1:0] == 2'h0 ? 24 : 32);
        e = 12'hFFF;
        for (int i = 0; i < n; i++) e[i] = d[i];
        if (np == 1) e[n] = par(f, d);
        len = (1 + n + np) * 16 + st;
        apb(1'b1, ULF_OFS_IST, 32'hF);
        apb(1'b1, ULF_OFS_IMSK, 32'h1);
        apb(1'b1, ULF_OFS_LFC, {24'h0, f});
        apb(1'b1, ULF_OFS_TXD, {24'h0, d});
        u_rem.grab(n + np + 1);
        chk(u_rem.smp, e);
        wirq();
        t = u_rem.cyc - u_rem.t0;
        chk(32'(t >= len - 2 && t <= len + 4), 1);
        apb(1'b1, ULF_OFS_IST, 32'hF);
        repeat (2) @(posedge clk);
        chk(irq, 0);
    endtask : t_tx
    task automatic t_rx(input logic [7:0] f, input logic [7:0] d, input logic p);
        apb(1'b1, ULF_OFS_IST, 32'hF);
        apb(1'b1, ULF_OFS_IMSK, 32'h2);
        apb(1'b1, ULF_OFS_LFC, {24'h0, f});
        u_rem.send(d, 5 + f[1:0], f[3], p);
        wirq();
        apb(1'b0, ULF_OFS_RXD, 32'h0);
        chk(rd[9:0], {2'b00, p ^ par(f, d), d});
    endtask : t_rx
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, ULF_OFS_LFC, 32'h0);
        chk(rd, 32'h0);
        chk({txd, irq}, 2'b10);
        apb(1'b0, ULF_OFS_DIV, 32'h0);
        chk(er, 1);
        apb(1'b1, ULF_OFS_LFC, 32'h80);
        apb(1'b1, ULF_OFS_EFR, 32'h5A);
        apb(1'b0, ULF_OFS_EFR, 32'h0);
        chk({er, rd}, 33'h05A);
        apb(1'b0, ULF_OFS_DIV, 32'h0);
        chk({er, rd}, 33'h001);
        apb(1'b1, ULF_OFS_LFC, 32'h00);
        apb(1'b0, ULF_OFS_EFR, 32'h0);
        chk({er, rd}, 33'h100000000);
        t_tx(8'h00, 8'hB3);
        t_tx(8'h04, 8'h4C);
        t_tx(8'h07, 8'hA5);
        t_tx(8'h09, 8'h2D);
        t_tx(8'h1A, 8'h6B);
        t_tx(8'h2B, 8'hF0);
        t_tx(8'h3E, 8'h0F);
        t_tx(8'h31, 8'h3C);
        t_rx(8'h1B, 8'h35, 1'b0);
        t_rx(8'h1B, 8'h35, 1'b1);
        t_rx(8'h3A, 8'h7F, 1'b1);
        t_rx(8'h09, 8'h3F, 1'b1);
        // a masked event must leave the line quiet yet stay visible in status
        apb(1'b1, ULF_OFS_IMSK, 32'h0);
        apb(1'b1, ULF_OFS_IST, 32'hF);
        apb(1'b1, ULF_OFS_TXD, 32'h55);
        repeat (300) @(posedge clk);
        chk(irq, 0);
        apb(1'b0, ULF_OFS_IST, 32'h0);
        chk(rd[0], 1);
        apb(1'b1, ULF_OFS_LFC, 32'h40);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            chk(txd, 0);
        end
        apb(1'b1, ULF_OFS_LFC, 32'h00);
        repeat (2) @(posedge clk);
        chk(txd, 1);
        results();
    end
endmodule : uart_line_format_control_test
`default_nettype wire
